// ### design/spic_consts.vh
`ifndef SPIC_CONSTS_VH
`define SPIC_CONSTS_VH
// Configuration dword byte offsets
`define SPIC_OFS_ID        8'h00
`define SPIC_OFS_CMD       8'h04
// Identification defaults, arbitrary neutral values
`define SPIC_MAKER_RST     16'h1AB0
`define SPIC_PART_RST      16'h0C01
// Command field positions
`define SPIC_CMD_IO        0
`define SPIC_CMD_MEM       1
`define SPIC_CMD_MASTER    2
`define SPIC_CMD_PARITY    6
`define SPIC_CMD_ERR       8
`define SPIC_CMD_INTX_OFF  10
// Writable command bits and reset value
`define SPIC_CMD_WMASK     16'h0547
`define SPIC_CMD_RST       16'h0000
`endif

// ### design/spic_gate.v
`include "spic_consts.vh"
// Turns the command bits into per-request decisions
module spic_gate (
  input  wire [15:0] cmd,        // Current command register
  input  wire        io_req,     // I/O request on primary side
  input  wire        mem_req,    // Memory request on primary side
  input  wire        up_req,     // Mem/IO request arriving from downstream
  input  wire        up_np,      // That request is non-posted
  input  wire        par_err,    // Parity error detected
  input  wire        err_det,    // Fatal/non-fatal error detected
  input  wire        intx_own,   // Port's own interrupt wish
  input  wire        intx_fwd,   // INTx arriving from downstream
  output wire        io_accept,  // Respond to I/O request
  output wire        mem_accept, // Respond to memory request
  output wire        up_fwd,     // Forward upstream
  output wire        up_ur,      // Treat as unsupported request
  output wire        up_ur_cpl,  // Return UR completion
  output wire        par_act,    // Take parity error action
  output wire        err_send,   // Send error message to root
  output wire        intx_out    // INTx message to send upstream
);
  // Decoding enables
  assign io_accept  = io_req  & cmd[`SPIC_CMD_IO];
  assign mem_accept = mem_req & cmd[`SPIC_CMD_MEM];
  // Upstream mastering
  assign up_fwd    = up_req & cmd[`SPIC_CMD_MASTER];
  assign up_ur     = up_req & ~cmd[`SPIC_CMD_MASTER];
  assign up_ur_cpl = up_ur & up_np;
  // Error handling; parity ignored when disabled
  assign par_act  = par_err & cmd[`SPIC_CMD_PARITY];
  assign err_send = err_det & cmd[`SPIC_CMD_ERR];
  // Disable gates only own interrupts, never forwarded ones
  assign intx_out = (intx_own & ~cmd[`SPIC_CMD_INTX_OFF]) | intx_fwd;
endmodule

// ### design/spic_regs.v
`include "spic_consts.vh"
module spic_regs (
  input  wire        clk,        // 40 MHz port clock
  input  wire        resetn,     // Async reset, active low
  input  wire        cfg_wr,     // Config write strobe
  input  wire        cfg_rd,     // Config read strobe
  input  wire [7:0]  cfg_addr,   // Config byte offset
  input  wire [3:0]  cfg_be,     // Byte enables
  input  wire [31:0] cfg_wdata,  // Write data
  output reg  [31:0] cfg_rdata,  // Read data, registered
  output reg         cfg_rvalid, // Read data valid pulse
  input  wire        load_we,    // SMBus/EEPROM id load strobe
  input  wire [15:0] load_maker, // Loaded maker code
  input  wire [15:0] load_part,  // Loaded part code
  input  wire        io_req,     // I/O request on primary
  input  wire        mem_req,    // Memory request on primary
  input  wire        up_req,     // Request from downstream
  input  wire        up_np,      // That request is non-posted
  input  wire        par_err,    // Parity error seen
  input  wire        err_det,    // Fatal/non-fatal error seen
  input  wire        intx_own,   // Own interrupt request
  input  wire        intx_fwd,   // Forwarded INTx
  output wire        io_accept,  // Respond to I/O
  output wire        mem_accept, // Respond to memory
  output wire        up_fwd,     // Forward upstream
  output wire        up_ur,      // Unsupported request
  output wire        up_ur_cpl,  // UR completion
  output wire        par_act,    // Parity action
  output wire        error_report_gate, // Error reporting enabled
  output wire        err_send,   // Error message out
  output wire        intx_out    // INTx out
);
  reg  [15:0] maker_code;   // Vendor-style identity
  reg  [15:0] part_code;    // Device-style identity
  reg  [15:0] port_command; // Stored command bits
  wire [15:0] wmask;        // Byte-enabled writable bits
  wire [15:0] next_command; // Command after write

  // Identity changes only via the side load path, not via config writes
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      maker_code <= `SPIC_MAKER_RST;
      part_code  <= `SPIC_PART_RST;
    end else if (load_we) begin
      maker_code <= load_maker;
      part_code  <= load_part;
    end
  end

  // Only RW bits in enabled bytes take the write; hardwired bits stay zero
  assign wmask = `SPIC_CMD_WMASK & {{8{cfg_be[1]}}, {8{cfg_be[0]}}};
  assign next_command = (port_command & ~wmask) | (cfg_wdata[15:0] & wmask);

  // Command register update
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port_command <= `SPIC_CMD_RST;
    end else if (cfg_wr && cfg_addr == `SPIC_OFS_CMD) begin
      port_command <= next_command;
    end
  end

  // Registered read; unmapped offsets and status half read zero
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_rdata  <= 32'h00000000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        case (cfg_addr)
          `SPIC_OFS_ID:  cfg_rdata <= {part_code, maker_code};
          `SPIC_OFS_CMD: cfg_rdata <= {16'h0000, port_command};
          default:       cfg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  assign error_report_gate = port_command[`SPIC_CMD_ERR];

  // Request gating from command bits
  spic_gate u_gate (
    .cmd        (port_command),
    .io_req     (io_req),
    .mem_req    (mem_req),
    .up_req     (up_req),
    .up_np      (up_np),
    .par_err    (par_err),
    .err_det    (err_det),
    .intx_own   (intx_own),
    .intx_fwd   (intx_fwd),
    .io_accept  (io_accept),
    .mem_accept (mem_accept),
    .up_fwd     (up_fwd),
    .up_ur      (up_ur),
    .up_ur_cpl  (up_ur_cpl),
    .par_act    (par_act),
    .err_send   (err_send),
    .intx_out   (intx_out)
  );
endmodule

// ### verif/spic_props.sv
module spic_props (
  input wire        clk, resetn, cfg_wr, cfg_rd, cfg_rvalid, io_req, io_accept, // Watched
  input wire        up_req, up_np, up_fwd, up_ur, up_ur_cpl, par_err, par_act,  // Watched
  input wire        error_report_gate, intx_fwd, intx_out,                      // Watched
  input wire [7:0]  cfg_addr,                                                   // Offset
  input wire [3:0]  cfg_be,                                                     // Lanes
  input wire [31:0] cfg_wdata, cfg_rdata                                        // Data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Command writes per byte lane
  wire cw0 = cfg_wr && cfg_addr == 8'h04 && cfg_be[0];
  wire cw1 = cfg_wr && cfg_addr == 8'h04 && cfg_be[1];
  property p_rv; cfg_rd |=> cfg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read answer missing");
  property p_io; cw0 |=> io_accept == (io_req && $past(cfg_wdata[0])); endproperty
  a_io: assert property (p_io) else $error("io gate wrong");
  property p_par; cw0 |=> par_act == (par_err && $past(cfg_wdata[6])); endproperty
  a_par: assert property (p_par) else $error("parity gate wrong");
  property p_gate; cw1 |=> error_report_gate == $past(cfg_wdata[8]); endproperty
  a_gate: assert property (p_gate) else $error("error gate wrong");
  property p_up; up_req |-> (up_fwd ^ up_ur); endproperty
  a_up: assert property (p_up) else $error("upstream decision wrong");
  property p_cpl; up_ur_cpl == (up_ur && up_np); endproperty
  a_cpl: assert property (p_cpl) else $error("completion wrong");
  property p_intx; intx_fwd |-> intx_out; endproperty
  a_intx: assert property (p_intx) else $error("forward blocked");
  property p_rsv; cfg_rd && cfg_addr == 8'h04 |=> (cfg_rdata & 32'hFFFFFAB8) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("fixed bits set");
  c_ur: cover property (up_ur_cpl);
  c_fwd: cover property (up_fwd);
  c_gate: cover property (cw1 ##1 error_report_gate);
endmodule

// ### verif/spic_host.sv
// Configuration requester on the primary side
module spic_host (
  input  wire         clk,       // Port clock
  input  wire  [31:0] cfg_rdata, // Read answer
  output logic        cfg_wr,    // Write strobe
  output logic        cfg_rd,    // Read strobe
  output logic [7:0]  cfg_addr,  // Offset
  output logic [3:0]  cfg_be,    // Lanes
  output logic [31:0] cfg_wdata  // Write data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
  // Data lines scrambled after release so stale data never looks valid
  task automatic wr(input [7:0] a, input [3:0] b, input [31:0] d);
    @(posedge clk) {cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, a, b, d};
    @(posedge clk) {cfg_wr, cfg_wdata} <= {1'b0, ~d};
  endtask
  // Answer is registered, so take it once it has settled
  task automatic rd(input [7:0] a, output [31:0] d);
    @(posedge clk) {cfg_rd, cfg_addr} <= {1'b1, a};
    @(posedge clk) cfg_rd <= 1'b0;
    #1 d = cfg_rdata;
  endtask
endmodule

// ### verif/testbench.sv
`include "spic_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, resetn = 0, load_we = 0;
  logic [15:0] load_maker = 16'h0000, load_part = 16'h0000;
  logic [7:0] req = 8'h00; // io mem up np par err own fwd
  logic [31:0] d;
  int errors = 0, n_compared = 0;
  wire cfg_wr, cfg_rd, cfg_rvalid, io_accept, mem_accept, up_fwd, up_ur, up_ur_cpl;
  wire par_act, error_report_gate, err_send, intx_out;
  wire [7:0] cfg_addr;
  wire [3:0] cfg_be;
  wire [31:0] cfg_wdata, cfg_rdata;
  initial forever #12.5 clk = ~clk;
  spic_regs dut_u (.*, .io_req(req[7]), .mem_req(req[6]), .up_req(req[5]), .up_np(req[4]),
    .par_err(req[3]), .err_det(req[2]), .intx_own(req[1]), .intx_fwd(req[0]));
  spic_host host_u (.*);
  task automatic chk(input [31:0] got, input [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Drive request pins, compare all decisions against command value c
  task automatic pins(input [7:0] r, input [15:0] c);
    @(posedge clk) req <= r;
    @(negedge clk) chk({23'h0, io_accept, mem_accept, up_fwd, up_ur, up_ur_cpl, par_act,
      error_report_gate, err_send, intx_out}, {23'h0, r[7] & c[0], r[6] & c[1], r[5] & c[2],
      r[5] & ~c[2], r[5] & ~c[2] & r[4], r[3] & c[6], c[8], r[2] & c[8], r[1] & ~c[10] | r[0]});
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    host_u.rd(8'h00, d);
    chk(d, {`SPIC_PART_RST, `SPIC_MAKER_RST});
    pins(8'hFF, 16'h0000);
    host_u.wr(8'h04, 4'h3, 32'hFFFFFFFF);
    host_u.rd(8'h04, d);
    chk(d, 32'h00000547);
    pins(8'hFF, 16'h0547);
    pins(8'h02, 16'h0547);
    // Low lane only: bits 8 and 10 keep their value
    host_u.wr(8'h04, 4'h1, 32'h0);
    pins(8'hEF, 16'h0500);
    host_u.wr(8'h00, 4'hF, 32'hFFFFFFFF);
    host_u.wr(8'h08, 4'hF, 32'hFFFFFFFF);
    host_u.rd(8'h00, d);
    chk(d, {`SPIC_PART_RST, `SPIC_MAKER_RST});
    host_u.rd(8'h08, d);
    chk(d, 32'h0);
    @(posedge clk) {load_we, load_maker, load_part} <= {1'b1, 16'hA5C3, 16'h3C5A};
    @(posedge clk) load_we <= 1'b0;
    host_u.rd(8'h00, d);
    chk(d, 32'h3C5AA5C3);
    @(posedge clk) resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    host_u.rd(8'h04, d);
    chk(d, 32'h0);
    final_report();
  end
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    final_report();
  end
endmodule
bind spic_regs spic_props props_u (.*);
